// ==== hdl/rtc_mode_pkg.sv ====
package rtc_mode_pkg;
	// ------------------------------------------------------------
	// calendar limits, field reset values, binary width and mode codes
	// ------------------------------------------------------------
	localparam int unsigned YEAR_BASE       = 2000;
	localparam int unsigned YEAR_LAST       = 2099;
	localparam logic [6:0]  YEAR_SPAN       = 7'd99;
	localparam logic [5:0]  SEC_LAST        = 6'd59;
	localparam logic [5:0]  MIN_LAST        = 6'd59;
	localparam logic [4:0]  HOUR_LAST       = 5'd23;
	localparam logic [3:0]  MONTH_LAST      = 4'd12;
	localparam logic [4:0]  DAY_FIRST       = 5'd1;
	localparam logic [3:0]  MONTH_FIRST     = 4'd1;
	localparam logic [6:0]  YEAR_RESET      = 7'h00;
	localparam int unsigned BIN_WIDTH       = 32;
	localparam logic [31:0] BIN_RESET       = 32'h0000_0000;
	localparam logic        OPMODE_NORMAL   = 1'b0;
	localparam logic        CNTMODE_CAL     = 1'b0;
	localparam logic        CNTMODE_BIN     = 1'b1;

	// ------------------------------------------------------------
	// tick timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned TICK_PERIOD_S   = 1;
	localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;
endpackage

// ==== hdl/rtc_wrap_counter.sv ====
`timescale 1ns/1ps
module rtc_wrap_counter
	import rtc_mode_pkg::*;
#(
	parameter int unsigned WIDTH = 6,
	parameter logic [WIDTH-1:0] FIRST = '0
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             step,
	input  wire logic [WIDTH-1:0] last,
	output logic      [WIDTH-1:0] value,
	output logic                  carry
);
	// a zero-width field cannot hold any count
	if (WIDTH < 1) begin : g_width_check
		$error("WIDTH must be at least 1");
	end

	assign carry = step && (value == last);

	always_ff @(posedge ref_clk) begin
		if (!rst_n || clear) begin
			value <= FIRST;
		end else if (carry) begin
			value <= FIRST;
		end else if (step) begin
			value <= value + WIDTH'(1);
		end
	end
endmodule

// ==== hdl/rtc_mode_core.sv ====
`timescale 1ns/1ps
module rtc_mode_core
	import rtc_mode_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        operating_mode_select,
	input  wire logic        count_mode_wr,
	input  wire logic        count_mode_wdata,
	input  wire logic        soft_reset,
	input  wire logic        alarm_match,
	output logic             count_mode_select,
	output logic             count_mode_active,
	output logic             low_power_active,
	output logic             alarm_irq,
	output logic             second_tick,
	output logic [5:0]       cal_sec,
	output logic [5:0]       cal_min,
	output logic [4:0]       cal_hour,
	output logic [4:0]       cal_day,
	output logic [3:0]       cal_month,
	output logic [6:0]       cal_year,
	output logic [31:0]      bin_seconds
);
	// a divider below two would tick on every edge and never idle
	if (TICK_DIV < 2) begin : g_div_check
		$error("TICK_DIV must be at least 2");
	end

	// ------------------------------------------------------------
	// one-second tick
	// ------------------------------------------------------------
	logic [31:0] div_cnt;
	logic        tick;
	assign tick = (div_cnt == 32'(TICK_DIV - 1));

	always_ff @(posedge ref_clk) begin
		if (!rst_n || soft_reset) begin
			div_cnt <= 32'h0000_0000;
		end else if (tick) begin
			div_cnt <= 32'h0000_0000;
		end else begin
			div_cnt <= div_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			second_tick <= 1'b0;
		end else begin
			second_tick <= tick && !soft_reset;
		end
	end

	// ------------------------------------------------------------
	// mode selection
	// ------------------------------------------------------------
	// the select bit updates here on the count clock, so software sees
	// it only one edge after its write and must poll it back
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_mode_select <= CNTMODE_CAL;
		end else if (count_mode_wr) begin
			count_mode_select <= count_mode_wdata;
		end
	end

	// the counter keeps its old mode until a software reset, so a stray
	// write cannot corrupt a running count
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_mode_active <= CNTMODE_CAL;
		end else if (soft_reset) begin
			count_mode_active <= count_mode_select;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			low_power_active <= 1'b0;
		end else begin
			low_power_active <= (operating_mode_select != OPMODE_NORMAL);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			alarm_irq <= 1'b0;
		end else begin
			alarm_irq <= alarm_match && tick &&
				(operating_mode_select == OPMODE_NORMAL);
		end
	end

	// ------------------------------------------------------------
	// binary count
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n || soft_reset) begin
			bin_seconds <= BIN_RESET;
		end else if (tick && count_mode_active == CNTMODE_BIN) begin
			bin_seconds <= bin_seconds + 32'h0000_0001;
		end
	end

	// ------------------------------------------------------------
	// calendar count
	// ------------------------------------------------------------
	logic       cal_step;
	logic       sec_c;
	logic       min_c;
	logic       hour_c;
	logic       day_c;
	logic       mon_c;
	logic [4:0] day_last;
	logic       leap;
	logic [5:0] sec_v;
	logic [5:0] min_v;
	logic [4:0] hour_v;
	logic [4:0] day_v;
	logic [3:0] mon_v;
	logic [6:0] year_v;

	assign cal_step = tick && (count_mode_active == CNTMODE_CAL);
	// every year divisible by four in 2000..2099 is a leap year
	assign leap = (year_v[1:0] == 2'b00);

	always_comb begin
		unique case (mon_v)
			4'h2:    day_last = leap ? 5'd29 : 5'd28;
			4'h4,
			4'h6,
			4'h9,
			4'hb:    day_last = 5'd30;
			default: day_last = 5'd31;
		endcase
	end

	rtc_wrap_counter #(.WIDTH(6), .FIRST(6'd0)) u_sec (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (soft_reset),
		.step    (cal_step),
		.last    (SEC_LAST),
		.value   (sec_v),
		.carry   (sec_c)
	);
	rtc_wrap_counter #(.WIDTH(6), .FIRST(6'd0)) u_min (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (soft_reset),
		.step    (sec_c),
		.last    (MIN_LAST),
		.value   (min_v),
		.carry   (min_c)
	);
	rtc_wrap_counter #(.WIDTH(5), .FIRST(5'd0)) u_hour (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (soft_reset),
		.step    (min_c),
		.last    (HOUR_LAST),
		.value   (hour_v),
		.carry   (hour_c)
	);
	rtc_wrap_counter #(.WIDTH(5), .FIRST(DAY_FIRST)) u_day (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (soft_reset),
		.step    (hour_c),
		.last    (day_last),
		.value   (day_v),
		.carry   (day_c)
	);
	rtc_wrap_counter #(.WIDTH(4), .FIRST(MONTH_FIRST)) u_mon (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (soft_reset),
		.step    (day_c),
		.last    (MONTH_LAST),
		.value   (mon_v),
		.carry   (mon_c)
	);
	rtc_wrap_counter #(.WIDTH(7), .FIRST(YEAR_RESET)) u_year (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (soft_reset),
		.step    (mon_c),
		.last    (YEAR_SPAN),
		.value   (year_v),
		.carry   ()
	);

	// outputs registered so the top drives only flip-flops
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cal_sec   <= 6'h00;
			cal_min   <= 6'h00;
			cal_hour  <= 5'h00;
			cal_day   <= DAY_FIRST;
			cal_month <= MONTH_FIRST;
			cal_year  <= YEAR_RESET;
		end else begin
			cal_sec   <= sec_v;
			cal_min   <= min_v;
			cal_hour  <= hour_v;
			cal_day   <= day_v;
			cal_month <= mon_v;
			cal_year  <= year_v;
		end
	end
endmodule

// ==== test/rtc_mode_core_properties.sv ====
`timescale 1ns/1ps
module rtc_mode_core_properties
	import rtc_mode_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        operating_mode_select,
	input wire logic        count_mode_wr,
	input wire logic        count_mode_wdata,
	input wire logic        soft_reset,
	input wire logic        count_mode_select,
	input wire logic        count_mode_active,
	input wire logic        low_power_active,
	input wire logic        alarm_irq,
	input wire logic        second_tick,
	input wire logic [4:0]  cal_day,
	input wire logic [3:0]  cal_month,
	input wire logic [6:0]  cal_year,
	input wire logic [5:0]  cal_sec,
	input wire logic [31:0] bin_seconds
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	op_mode_a: assert property ($past(rst_n) |->
		low_power_active == $past(operating_mode_select))
		else $error("low power flag off");
	alarm_gate_a: assert property (low_power_active &&
		$past(low_power_active) |-> !alarm_irq) else $error("alarm in lp");
	year_range_a: assert property (cal_year <= 7'h63)
		else $error("year out of range");
	leap_day_a: assert property (cal_month == 4'h2 |->
		cal_day <= ((cal_year[1:0] == 2'h0) ? 5'h1d : 5'h1c))
		else $error("february day");
	bin_step_a: assert property (second_tick && count_mode_active &&
		$past(rst_n) && !$past(soft_reset) |->
		bin_seconds == $past(bin_seconds) + 32'h1) else $error("bin step");
	cal_hold_a: assert property (count_mode_active &&
		$past(count_mode_active) |=> $stable(cal_sec))
		else $error("calendar moved");
	select_sync_a: assert property (count_mode_wr |=>
		count_mode_select == $past(count_mode_wdata)) else $error("select");
	mode_hold_a: assert property (!soft_reset |=>
		$stable(count_mode_active)) else $error("mode changed");
	mode_load_a: assert property (soft_reset |=>
		count_mode_active == $past(count_mode_select)) else $error("load");
endmodule

bind rtc_mode_core rtc_mode_core_properties u_props (
	.ref_clk               (ref_clk),
	.rst_n                 (rst_n),
	.operating_mode_select (operating_mode_select),
	.count_mode_wr         (count_mode_wr),
	.count_mode_wdata      (count_mode_wdata),
	.soft_reset            (soft_reset),
	.count_mode_select     (count_mode_select),
	.count_mode_active     (count_mode_active),
	.low_power_active      (low_power_active),
	.alarm_irq             (alarm_irq),
	.second_tick           (second_tick),
	.cal_day               (cal_day),
	.cal_month             (cal_month),
	.cal_year              (cal_year),
	.cal_sec               (cal_sec),
	.bin_seconds           (bin_seconds)
);

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; \
	$display("mismatch %s expected %0h seen %0h", n, e, a); end end
module testbench;
	import rtc_mode_pkg::*;
	logic ref_clk = 0, rst_n = 0, op = 0, wr = 0, wd = 0, sr = 0, am = 0;
	logic sel, act, lp, irq, tick;
	logic [5:0] sec, min;
	logic [4:0] hr, day;
	logic [3:0] mon;
	logic [6:0] yr;
	logic [31:0] bin;
	int errors = 0, num_checks = 0;
	rtc_mode_core #(.TICK_DIV(4)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.operating_mode_select(op), .count_mode_wr(wr),
		.count_mode_wdata(wd), .soft_reset(sr), .alarm_match(am),
		.count_mode_select(sel), .count_mode_active(act),
		.low_power_active(lp), .alarm_irq(irq), .second_tick(tick),
		.cal_sec(sec), .cal_min(min), .cal_hour(hr), .cal_day(day),
		.cal_month(mon), .cal_year(yr), .bin_seconds(bin));
	initial forever #20 ref_clk = ~ref_clk;
	task summarize;
		if (errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// bounded wait for n ticks, then let the calendar lag settle
	task ticks(input int n);
		int k;
		int lim;
		k = 0;
		lim = 5 * n + 8;
		while (n > 0) begin
			@(negedge ref_clk);
			k++;
			if (tick === 1'b1) n--;
			if (k > lim) begin errors++; summarize; end
		end
		repeat (2) @(negedge ref_clk);
	endtask
	task set_mode(input logic m);
		@(posedge ref_clk) begin wr <= 1; wd <= m; end
		@(posedge ref_clk) wr <= 0;
		@(negedge ref_clk);
		`CHK("select", m, sel)
		`CHK("active", ~m, act)
		@(posedge ref_clk) sr <= 1;
		@(posedge ref_clk) sr <= 0;
		@(negedge ref_clk);
		`CHK("active", m, act)
		`CHK("bin", 32'h0, bin)
	endtask
	task binary_run;
		set_mode(1);
		ticks(3);
		`CHK("bin", 32'h3, bin)
		`CHK("sec", 6'h0, sec)
	endtask
	task calendar_run;
		set_mode(0);
		ticks(2);
		`CHK("sec", 6'h2, sec)
		`CHK("day", 5'h1, day)
		`CHK("year", 7'h0, yr)
		ticks(58);
		`CHK("sec", 6'h0, sec)
		`CHK("min", 6'h1, min)
		`CHK("mon", MONTH_FIRST, mon)
		ticks(3540);
		`CHK("min", 6'h0, min)
		`CHK("hour", 5'h1, hr)
	endtask
	// mid-run reset: select, active mode, binary count, hour, day, month and lp return to reset values
	task reset_run;
		@(posedge ref_clk) rst_n <= 0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		`CHK("select", CNTMODE_CAL, sel)
		`CHK("active", CNTMODE_CAL, act)
		`CHK("bin", BIN_RESET, bin)
		`CHK("hour", 5'h0, hr)
		`CHK("day", DAY_FIRST, day)
		`CHK("mon", MONTH_FIRST, mon)
		`CHK("lp", 1'b0, lp)
		@(posedge ref_clk) rst_n <= 1;
		repeat (2) @(negedge ref_clk);
		`CHK("lp", 1'b1, lp)
	endtask
	task alarm_run(input logic m);
		int seen;
		seen = 0;
		@(posedge ref_clk) begin op <= m; am <= 1; end
		repeat (12) begin @(negedge ref_clk); seen += (irq === 1'b1); end
		`CHK("lp", m, lp)
		`CHK("irq", (m == OPMODE_NORMAL), seen > 0)
		@(posedge ref_clk) am <= 0;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1;
		binary_run;
		calendar_run;
		alarm_run(0);
		alarm_run(1);
		reset_run;
		summarize;
	end
endmodule
